// ### rtl/pacc_top.sv
// Pulse accumulator: counter, control, flags and Avalon-MM register slave.
`timescale 1ns/1ps
`include "pacc_cfg.svh"
module pacc_top
#(
  parameter int CNT_W    = 8,
  parameter int GATE_DIV = `PACC_GATE_DIV
)
(
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic [3:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  input  wire logic        ACCUM_INPUT_PIN,
  output logic             PORT_A7_DIRECTION,
  output logic             ACCUM_OVERFLOW_IRQ,
  output logic             INPUT_EDGE_IRQ
);
  localparam int DIV_W = $clog2(GATE_DIV);

  if (CNT_W != 8)
  begin : g_bad_cnt_w
    $error("pacc_top: counter width must be 8");
  end
  if (GATE_DIV < 2 || (GATE_DIV & (GATE_DIV - 1)) != 0)
  begin : g_bad_div
    $error("pacc_top: gate divider must be a power of two");
  end

  pacc_pkg::pacc_bus_state_t bus_st_r;
  logic [3:0]       ctrl_r;
  logic [CNT_W-1:0] count_r;
  logic [1:0]       mask_r;
  logic [1:0]       flag_r;
  logic [DIV_W-1:0] div_r;
  logic [DIV_W:0]   gap_r;
  logic [31:0]      rdata_r;
  logic             pin_lvl;
  logic             pin_rise;
  logic             pin_fall;
  logic             sel_edge;
  logic             gate_open;
  logic             tick;
  logic             inc;
  logic             wrap;
  logic             take;
  logic             wr_take;
  logic             byte0_wr;
  logic             en;
  logic             mode;
  logic             edge_sel;

  // ****************************************************************
  // Pin synchroniser
  // ****************************************************************
  pacc_sync pacc_sync_inst
  (
    .CLK       (CLK),
    .RST_N     (RST_N),
    .pin_in    (ACCUM_INPUT_PIN),   // The pin is sampled whatever its direction.
    .level_out (pin_lvl),
    .rise_out  (pin_rise),
    .fall_out  (pin_fall)
  );

  assign en       = ctrl_r[`PACC_CTRL_EN_BIT - 4];
  assign mode     = ctrl_r[`PACC_CTRL_MODE_BIT - 4];
  assign edge_sel = ctrl_r[`PACC_CTRL_EDGE_BIT - 4];

  // ****************************************************************
  // Counting logic
  // ****************************************************************
  assign sel_edge  = edge_sel ? pin_rise : pin_fall;
  assign gate_open = edge_sel ? !pin_lvl : pin_lvl;
  assign tick      = (div_r == DIV_W'(GATE_DIV - 1));
  assign inc       = en && (mode ? (tick && gate_open)
                                 : sel_edge);
  assign wrap      = inc && (count_r == {CNT_W{1'b1}});

  // The divider is free running so gated time does not depend on the gate.
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      div_r <= '0;
    else
      div_r <= div_r + DIV_W'(1);
  end

  // Cycles since the last gated increment, saturating; only the assertions read it.
  // Outside gated mode it stays saturated, so a mode change never looks like a fast count.
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      gap_r <= '1;
    else if (!mode)
      gap_r <= '1;
    else if (inc)
      gap_r <= '0;
    else if (gap_r != '1)
      gap_r <= gap_r + (DIV_W + 1)'(1);
  end

  // ****************************************************************
  // Avalon-MM slave: one wait cycle, then the answer
  // ****************************************************************
  assign take     = (bus_st_r == pacc_pkg::PACC_BUS_WAIT);
  assign wr_take  = take && AVS_WRITE;
  assign byte0_wr = wr_take && AVS_BYTEENABLE[0];
  assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !take;
  assign AVS_READDATA    = rdata_r;

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      bus_st_r <= pacc_pkg::PACC_BUS_IDLE;
    else
    begin
      unique case (bus_st_r)
        pacc_pkg::PACC_BUS_IDLE:
          if (AVS_READ || AVS_WRITE)
            bus_st_r <= pacc_pkg::PACC_BUS_WAIT;
        pacc_pkg::PACC_BUS_WAIT:
          bus_st_r <= pacc_pkg::PACC_BUS_DONE;
        pacc_pkg::PACC_BUS_DONE:
          bus_st_r <= pacc_pkg::PACC_BUS_IDLE;
      endcase
    end
  end

  // Read data is captured in the cycle before the taking edge, so a read
  // returns count_r as it stood before the capture edge; an increment on that edge or in the wait cycle is not seen.
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      rdata_r <= 32'h0000_0000;
    else if (bus_st_r == pacc_pkg::PACC_BUS_IDLE && AVS_READ)
    begin
      unique case (AVS_ADDRESS)
        `PACC_ADDR_CTRL:  rdata_r <= {24'h000000, ctrl_r, 4'h0};
        `PACC_ADDR_COUNT: rdata_r <= {24'h000000, count_r};
        `PACC_ADDR_MASK:  rdata_r <= {24'h000000, 2'h0, mask_r, 4'h0};
        `PACC_ADDR_FLAG:  rdata_r <= {24'h000000, 2'h0, flag_r, 4'h0};
        default:          rdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      ctrl_r <= `PACC_CTRL_RESET;
    else if (byte0_wr && AVS_ADDRESS == `PACC_ADDR_CTRL)
      ctrl_r <= AVS_WRITEDATA[7:4];
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      mask_r <= `PACC_MASK_RESET;
    else if (byte0_wr && AVS_ADDRESS == `PACC_ADDR_MASK)
      mask_r <= AVS_WRITEDATA[5:4];
  end

  // No reset term: the counter keeps its value through reset.
  always_ff @(posedge CLK)
  begin
    if (byte0_wr && AVS_ADDRESS == `PACC_ADDR_COUNT)
      count_r <= AVS_WRITEDATA[CNT_W-1:0];
    else if (inc)
      count_r <= count_r + CNT_W'(1);
  end

  // Hardware set wins over a software clear in the same cycle.
  generate
    for (genvar i = 0; i < 2; i++)
    begin : g_flag
      logic set_ev;
      logic clr_ev;
      assign set_ev = (i == 1) ? wrap
                               : (en && sel_edge);
      assign clr_ev = byte0_wr && AVS_ADDRESS == `PACC_ADDR_FLAG
                      && AVS_WRITEDATA[`PACC_EDGE_BIT + i];
      always_ff @(posedge CLK or negedge RST_N)
      begin
        if (!RST_N)
          flag_r[i] <= 1'b0;
        else if (set_ev)
          flag_r[i] <= 1'b1;
        else if (clr_ev)
          flag_r[i] <= 1'b0;
      end
    end
  endgenerate

  assign ACCUM_OVERFLOW_IRQ = flag_r[1] && mask_r[1];
  assign INPUT_EDGE_IRQ     = flag_r[0] && mask_r[0];
  assign PORT_A7_DIRECTION  = ctrl_r[`PACC_CTRL_DIR_BIT - 4];

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_overflow_sets: assert property (@(posedge CLK) disable iff (!RST_N)
    wrap |=> flag_r[1])
    else $error("overflow flag not set after wrap");

  a_wrap_to_zero: assert property (@(posedge CLK) disable iff (!RST_N)
    wrap && !wr_take |=> count_r == 8'h00)
    else $error("counter did not wrap to zero");

  a_edge_flag_sets: assert property (@(posedge CLK) disable iff (!RST_N)
    en && sel_edge |=> flag_r[0])
    else $error("edge flag not set on selected edge");

  a_disabled_hold: assert property (@(posedge CLK) disable iff (!RST_N)
    !en && !byte0_wr |=> $stable(count_r))
    else $error("counter moved while disabled");

  a_gate_blocks: assert property (@(posedge CLK) disable iff (!RST_N)
    mode && !gate_open |-> !inc)
    else $error("count while gate inhibited");

  a_gate_rate: assert property (@(posedge CLK) disable iff (!RST_N)
    mode && inc |-> gap_r >= {1'b0, DIV_W'(GATE_DIV - 1)})
    else $error("gated count faster than divider");

  a_ovf_clear: assert property (@(posedge CLK) disable iff (!RST_N)
    byte0_wr && AVS_ADDRESS == `PACC_ADDR_FLAG && AVS_WRITEDATA[5] && !wrap
    |=> !flag_r[1])
    else $error("overflow flag not cleared");

  a_irq_mask: assert property (@(posedge CLK) disable iff (!RST_N)
    !mask_r[1] |-> !ACCUM_OVERFLOW_IRQ)
    else $error("overflow request while masked");

  a_bus_answer: assert property (@(posedge CLK) disable iff (!RST_N)
    AVS_READ && bus_st_r == pacc_pkg::PACC_BUS_IDLE |=> !AVS_WAITREQUEST)
    else $error("bus answer late");

  a_count_write: assert property (@(posedge CLK) disable iff (!RST_N)
    byte0_wr && AVS_ADDRESS == `PACC_ADDR_COUNT
    |=> count_r == $past(AVS_WRITEDATA[7:0]))
    else $error("counter write lost");

  // ****************************************************************
  // Counter, control and bus assertions
  // ****************************************************************
  a_count_step: assert property (@(posedge CLK) disable iff (!RST_N)
    inc && !(byte0_wr && AVS_ADDRESS == `PACC_ADDR_COUNT)
    |=> count_r == $past(count_r) + CNT_W'(1))
    else $error("counter did not step by one");

  a_div_run: assert property (@(posedge CLK) disable iff (!RST_N)
    1'b1 |=> div_r == $past(div_r) + DIV_W'(1))
    else $error("divider not free running");

  a_mode_select: assert property (@(posedge CLK) disable iff (!RST_N)
    en && !mode |-> inc == sel_edge)
    else $error("event mode count not on selected edge");

  a_disabled_idle: assert property (@(posedge CLK) disable iff (!RST_N)
    !en |-> !inc)
    else $error("increment while disabled");

  a_ctrl_write: assert property (@(posedge CLK) disable iff (!RST_N)
    byte0_wr && AVS_ADDRESS == `PACC_ADDR_CTRL
    |=> ctrl_r == $past(AVS_WRITEDATA[7:4]))
    else $error("control write lost");

  a_mask_write: assert property (@(posedge CLK) disable iff (!RST_N)
    byte0_wr && AVS_ADDRESS == `PACC_ADDR_MASK
    |=> mask_r == $past(AVS_WRITEDATA[5:4]))
    else $error("mask write lost");

  a_lane_ignored: assert property (@(posedge CLK) disable iff (!RST_N)
    wr_take && !AVS_BYTEENABLE[0]
    |=> $stable(ctrl_r) && $stable(mask_r))
    else $error("write without byte lane changed a register");

  a_write_answer: assert property (@(posedge CLK) disable iff (!RST_N)
    AVS_WRITE && bus_st_r == pacc_pkg::PACC_BUS_IDLE |=> !AVS_WAITREQUEST)
    else $error("write answer late");

  a_read_hi_zero: assert property (@(posedge CLK) disable iff (!RST_N)
    take && AVS_READ |-> AVS_READDATA[31:8] == 24'h000000)
    else $error("read data upper bits not zero");

  a_flag_low_zero: assert property (@(posedge CLK) disable iff (!RST_N)
    take && AVS_READ && AVS_ADDRESS == `PACC_ADDR_FLAG |-> AVS_READDATA[3:0] == 4'h0)
    else $error("flag low bits not zero");

  // ****************************************************************
  // Flag, request and pin assertions
  // ****************************************************************
  a_edge_clear: assert property (@(posedge CLK) disable iff (!RST_N)
    byte0_wr && AVS_ADDRESS == `PACC_ADDR_FLAG && AVS_WRITEDATA[`PACC_EDGE_BIT]
    && !(en && sel_edge) |=> !flag_r[0])
    else $error("edge flag not cleared");

  a_edge_irq_mask: assert property (@(posedge CLK) disable iff (!RST_N)
    !mask_r[0] |-> !INPUT_EDGE_IRQ)
    else $error("edge request while masked");

  a_ovf_irq_set: assert property (@(posedge CLK) disable iff (!RST_N)
    flag_r[1] && mask_r[1] |-> ACCUM_OVERFLOW_IRQ)
    else $error("overflow request missing");

  a_edge_irq_set: assert property (@(posedge CLK) disable iff (!RST_N)
    flag_r[0] && mask_r[0] |-> INPUT_EDGE_IRQ)
    else $error("edge request missing");

  a_one_rise: assert property (@(posedge CLK) disable iff (!RST_N)
    pin_rise |=> !pin_rise)
    else $error("rising edge reported twice");

  a_one_fall: assert property (@(posedge CLK) disable iff (!RST_N)
    pin_fall |=> !pin_fall)
    else $error("falling edge reported twice");

  a_edge_excl: assert property (@(posedge CLK) disable iff (!RST_N)
    !(pin_rise && pin_fall))
    else $error("rise and fall reported together");

  // ****************************************************************
  // Cover points
  // ****************************************************************
  c_event_count: cover property (@(posedge CLK) disable iff (!RST_N)
    !mode && inc);

  c_gated_count: cover property (@(posedge CLK) disable iff (!RST_N)
    mode && inc);

  c_overflow: cover property (@(posedge CLK) disable iff (!RST_N)
    wrap);

  c_set_and_clear: cover property (@(posedge CLK) disable iff (!RST_N)
    wrap && byte0_wr && AVS_ADDRESS == `PACC_ADDR_FLAG);

  c_both_irqs: cover property (@(posedge CLK) disable iff (!RST_N)
    ACCUM_OVERFLOW_IRQ && INPUT_EDGE_IRQ);
endmodule

// ### rtl/pacc_cfg.svh
// Constants for the pulse accumulator: offsets, field positions, reset values and timing.
`ifndef PACC_CFG_SVH
`define PACC_CFG_SVH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define PACC_ADDR_CTRL      4'h0
`define PACC_ADDR_COUNT     4'h4
`define PACC_ADDR_MASK      4'h8
`define PACC_ADDR_FLAG      4'hC

// ****************************************************************
// Field positions
// ****************************************************************
`define PACC_CTRL_DIR_BIT   7
`define PACC_CTRL_EN_BIT    6
`define PACC_CTRL_MODE_BIT  5
`define PACC_CTRL_EDGE_BIT  4
`define PACC_OVF_BIT        5
`define PACC_EDGE_BIT       4

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define PACC_CTRL_RESET     4'h0
`define PACC_MASK_RESET     2'h0
`define PACC_FLAG_RESET     2'h0
`define PACC_GATE_DIV       64

`endif

// ### rtl/pacc_pkg.sv
// Types shared by the pulse accumulator modules.
package pacc_pkg;
  typedef enum logic [1:0] {
    PACC_BUS_IDLE,
    PACC_BUS_WAIT,
    PACC_BUS_DONE
  } pacc_bus_state_t;
endpackage

// ### rtl/pacc_sync.sv
// Three-stage synchroniser for the accumulator input pin.
`timescale 1ns/1ps
module pacc_sync
(
  input  wire logic CLK,
  input  wire logic RST_N,
  input  wire logic pin_in,
  output logic      level_out,
  output logic      rise_out,
  output logic      fall_out
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic lvl_r;

  // ****************************************************************
  // Sampling chain
  // ****************************************************************
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end
    else
    begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // A change counts only once the second and third stage agree.
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      lvl_r <= 1'b0;
    else if (s2_r == s3_r)
      lvl_r <= s3_r;
  end

  assign level_out = lvl_r;
  assign rise_out  = (s2_r == s3_r) && s3_r && !lvl_r;
  assign fall_out  = (s2_r == s3_r) && !s3_r && lvl_r;
endmodule

// ### testbench/pacc_pin_model.sv
// Model of the external source that drives the accumulator input pin.
`timescale 1ns/1ps
module pacc_pin_model
#(
  parameter int HOLD = 4
)
(
  input  wire logic CLK,
  input  wire logic RST_N,
  input  wire logic level_req,
  output logic      pin
);
  logic [3:0] age_r;

  // ****************************************************************
  // Pin driver
  // ****************************************************************
  // A level is held for at least HOLD+1 cycles before it may change again.
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      pin   <= 1'b0;
      age_r <= 4'h0;
    end
    else if (level_req !== pin && age_r >= HOLD)
    begin
      pin   <= level_req;
      age_r <= 4'h0;
    end
    else if (age_r != 4'hF)
      age_r <= age_r + 4'h1;
  end
endmodule

// ### testbench/tb_pacc_top.sv
// Self-checking testbench for the pulse accumulator.
`timescale 1ns/1ps
`include "pacc_cfg.svh"
module tb_pacc_top;
  logic        CLK = 1'b0;
  logic        RST_N = 1'b0;
  logic [3:0]  AVS_ADDRESS = 4'h0;
  logic        AVS_READ = 1'b0;
  logic        AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h0;
  logic [3:0]  AVS_BYTEENABLE = 4'hF;
  logic [31:0] AVS_READDATA;
  logic        AVS_WAITREQUEST;
  logic        ACCUM_INPUT_PIN;
  logic        PORT_A7_DIRECTION;
  logic        ACCUM_OVERFLOW_IRQ;
  logic        INPUT_EDGE_IRQ;
  logic        level_req = 1'b0;
  logic [31:0] seed = 32'h0269DF80;
  logic [31:0] last_rd;
  logic [32:0] exp_q[$];
  logic [32:0] note;
  logic [7:0]  start;
  logic [8:0]  sum;
  int          bad_count = 0;
  int          checks = 0;

  always #5 CLK = ~CLK;

  pacc_top #(.CNT_W(8), .GATE_DIV(8)) pacc_top_inst (.CLK(CLK), .RST_N(RST_N),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .ACCUM_INPUT_PIN(ACCUM_INPUT_PIN), .PORT_A7_DIRECTION(PORT_A7_DIRECTION),
    .ACCUM_OVERFLOW_IRQ(ACCUM_OVERFLOW_IRQ), .INPUT_EDGE_IRQ(INPUT_EDGE_IRQ));
  pacc_pin_model pacc_pin_model_inst (.CLK(CLK), .RST_N(RST_N), .level_req(level_req),
    .pin(ACCUM_INPUT_PIN));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic report_and_stop();
    if (bad_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Avalon master: request held until waitrequest is sampled low.
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
                     input logic [3:0] be, input logic [32:0] e);
    @(posedge CLK);
    AVS_ADDRESS <= a;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    AVS_WRITEDATA <= {24'h0, d};
    AVS_BYTEENABLE <= be;
    if (!w)
      exp_q.push_back(e);
    @(posedge CLK);
    while (AVS_WAITREQUEST !== 1'b0)
      @(posedge CLK);
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
    // Let the register update settle before the caller looks at outputs.
    @(posedge CLK);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'hF, 33'h0);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h0, 4'hF, {25'h0, e});
  endtask

  task automatic pulses(input int n);
    repeat (n)
    begin
      level_req <= 1'b1;
      repeat (6) @(posedge CLK);
      level_req <= 1'b0;
      repeat (6) @(posedge CLK);
    end
    repeat (8) @(posedge CLK);
  endtask

  // ****************************************************************
  // Read checker
  // ****************************************************************
  always @(posedge CLK)
  begin
    if (AVS_READ === 1'b1 && AVS_WAITREQUEST === 1'b0 && exp_q.size() > 0)
    begin
      note = exp_q.pop_front();
      last_rd = AVS_READDATA;
      if (!note[32])
        chk("readdata", note[31:0], AVS_READDATA);
    end
  end

  initial
  begin
    repeat (20000) @(posedge CLK);
    bad_count++;
    report_and_stop();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    repeat (20) @(posedge CLK);
    RST_N <= 1'b1;
    rd(`PACC_ADDR_CTRL, 8'h00);
    rd(`PACC_ADDR_MASK, 8'h00);
    rd(`PACC_ADDR_FLAG, 8'h00);
    rd(4'h1, 8'h00);
    wr(`PACC_ADDR_CTRL, 8'hDF);
    rd(`PACC_ADDR_CTRL, 8'hD0);
    chk("direction", 1, PORT_A7_DIRECTION);
    for (int e = 0; e < 2; e++)
    begin
      seed = xs(seed);
      start = (e == 0) ? seed[7:0] : {6'h3F, seed[1:0]};
      sum = {1'b0, start} + 9'h4;
      wr(`PACC_ADDR_CTRL, {3'h6, e[0], 4'h0});
      wr(`PACC_ADDR_COUNT, start);
      pulses(4);
      rd(`PACC_ADDR_COUNT, sum[7:0]);
      rd(`PACC_ADDR_FLAG, {2'h0, sum[8], 5'h10});
      chk("edge_irq", 0, INPUT_EDGE_IRQ);
      wr(`PACC_ADDR_MASK, 8'h30);
      chk("ovf_irq", sum[8], ACCUM_OVERFLOW_IRQ);
      chk("edge_irq", 1, INPUT_EDGE_IRQ);
      wr(`PACC_ADDR_FLAG, 8'h00);
      rd(`PACC_ADDR_FLAG, {2'h0, sum[8], 5'h10});
      wr(`PACC_ADDR_FLAG, 8'h10);
      rd(`PACC_ADDR_FLAG, {2'h0, sum[8], 5'h00});
      wr(`PACC_ADDR_FLAG, 8'h20);
      rd(`PACC_ADDR_FLAG, 8'h00);
      chk("ovf_irq", 0, ACCUM_OVERFLOW_IRQ);
      wr(`PACC_ADDR_MASK, 8'h00);
    end
    wr(`PACC_ADDR_CTRL, 8'h10);
    wr(`PACC_ADDR_COUNT, 8'h33);
    pulses(2);
    rd(`PACC_ADDR_COUNT, 8'h33);
    rd(`PACC_ADDR_FLAG, 8'h00);
    bus(1'b1, `PACC_ADDR_COUNT, 8'h77, 4'h0, 33'h0);
    rd(`PACC_ADDR_COUNT, 8'h33);
    wr(`PACC_ADDR_CTRL, 8'h60);
    wr(`PACC_ADDR_COUNT, 8'h00);
    repeat (80) @(posedge CLK);
    rd(`PACC_ADDR_COUNT, 8'h00);
    level_req <= 1'b1;
    repeat (12) @(posedge CLK);
    wr(`PACC_ADDR_COUNT, 8'h00);
    repeat (80) @(posedge CLK);
    bus(1'b0, `PACC_ADDR_COUNT, 8'h0, 4'hF, {1'b1, 32'h0});
    repeat (2) @(posedge CLK);
    chk("gated_count", 1, last_rd >= 32'h8 && last_rd <= 32'hC);
    wr(`PACC_ADDR_CTRL, 8'h70);
    wr(`PACC_ADDR_COUNT, 8'h00);
    repeat (80) @(posedge CLK);
    rd(`PACC_ADDR_COUNT, 8'h00);
    level_req <= 1'b0;
    repeat (12) @(posedge CLK);
    wr(`PACC_ADDR_FLAG, 8'h30);
    wr(`PACC_ADDR_CTRL, 8'h00);
    wr(`PACC_ADDR_COUNT, 8'h5A);
    RST_N <= 1'b0;
    repeat (5) @(posedge CLK);
    RST_N <= 1'b1;
    rd(`PACC_ADDR_COUNT, 8'h5A);
    rd(`PACC_ADDR_CTRL, 8'h00);
    repeat (4) @(posedge CLK);
    report_and_stop();
  end
endmodule
